// file: core/bsac_top.sv
// bsac_top: boost clock mode, start-up, adaptive target and supervision
// assumes analog comparators and pins are asynchronous to ref_clk;
// sink used/fault flags, ledActive and hostClear come from ref_clk logic
`timescale 1ns/1ps
module bsac_top
   import bsac_pkg::*;
#(
   parameter int UV_TIMEOUT_P = UV_TIMEOUT_CYC,
   parameter int SS_PAUSE_P   = SS_PAUSE_CYC,
   parameter int SS_MOD_P     = SS_MOD_CYC,
   parameter int DETECT_P     = DETECT_CYC,
   parameter int SYNC_LOSS_P  = SYNC_LOSS_CYC,
   parameter int RAMP_P       = RAMP_CYC,
   parameter int ADAPT_P      = ADAPT_CYC,
   parameter int RECOVER_P    = RECOVER_CYC
) (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   // pins
   input  wire logic               boostClockSyncInput,
   input  wire logic [STRAP_W-1:0] boostFrequencyStrap,
   input  wire logic               enablePin,
   // comparators
   input  wire logic               currentLimitHit,
   input  wire logic               overvoltageLowerLevel,
   input  wire logic               overvoltageUpperLevel,
   input  wire logic               undervoltageLevel,
   input  wire logic               thermalCrossing,
   input  wire logic [NSINK-1:0]   sinkBelowLow,
   input  wire logic [NSINK-1:0]   sinkAboveHigh,
   // same-domain sink state and host
   input  wire logic [NSINK-1:0]   sinkUsed,
   input  wire logic [NSINK-1:0]   sinkFault,
   input  wire logic               ledActive,
   input  wire logic               hostClear,
   // power stage
   output logic                    boostGate,
   output logic [TGT_W-1:0]        targetLevel,
   // mode and status
   output logic                    extSyncMode,
   output logic                    spreadActive,
   output logic                    faultRecovery,
   output bsac_status_t            status,
   // open-drain interrupt, low when asserted
   output logic                    intOut,
   output logic                    intOe
);
   localparam int AW  = 7 + STRAP_W + 2 * NSINK;
   localparam int UVW = $clog2(UV_TIMEOUT_P + 1);
   localparam int PSW = $clog2(SS_PAUSE_P + 1);
   localparam int SQW = $clog2(SS_MOD_P + 1);
   localparam int TKW = $clog2(DETECT_P + SYNC_LOSS_P + RAMP_P + ADAPT_P
                               + RECOVER_P + 1);

   typedef enum {ST_IDLE, ST_DETECT, ST_RAMP, ST_WAIT_LED, ST_ADAPT,
                 ST_RECOVER} bsac_state_t;

   bsac_state_t             state;
   bsac_state_t             next_state;
   logic [AW-1:0]           asyncMeta;
   logic [AW-1:0]           asyncSync;
   logic                    syncDly;
   logic                    enDly;
   logic                    thermDly;
   logic [STRAP_W-1:0]      strap;
   logic [TKW-1:0]          tick;
   logic [3:0]              edgeCnt;
   logic [TKW-1:0]          idleCnt;
   logic [PSW-1:0]          pauseCnt;
   logic [UVW-1:0]          uvCnt;
   logic [SQW-1:0]          stepCnt;
   logic signed [PER_W:0]   ssOffs;
   logic                    ssUp;
   bsac_status_t            next_status;
   logic [PER_W-1:0]        periodTab [8];
   logic signed [PER_W:0]   devTab [8];
   logic [SQW-1:0]          stepTab [8];

   // two-flop synchroniser for every pin and comparator
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         asyncMeta <= '0;
         asyncSync <= '0;
      end else begin
         asyncMeta <= {boostClockSyncInput, enablePin, currentLimitHit,
                       overvoltageLowerLevel, overvoltageUpperLevel,
                       undervoltageLevel, thermalCrossing,
                       boostFrequencyStrap, sinkBelowLow, sinkAboveHigh};
         asyncSync <= asyncMeta;
      end
   end

   // unpacked synchronised inputs, with the same-domain sink used/fault flags
   wire              sSync   = asyncSync[AW-1];
   wire              sEn     = asyncSync[AW-2];
   wire              sCurLim = asyncSync[AW-3];
   wire              sOvLow  = asyncSync[AW-4];
   wire              sOvHigh = asyncSync[AW-5];
   wire              sUv     = asyncSync[AW-6];
   wire              sTherm  = asyncSync[AW-7];
   wire [STRAP_W-1:0] sStrap = asyncSync[2*NSINK +: STRAP_W];
   bsac_sink_t       sink;
   assign sink.used  = sinkUsed;
   assign sink.fault = sinkFault;
   assign sink.low   = asyncSync[NSINK +: NSINK];
   assign sink.high  = asyncSync[0 +: NSINK];

   // constant per-strap tables of period, deviation and step spacing
   for (genvar i = 0; i < 8; i++) begin : g_tab
      assign periodTab[i] = PER_W'(period_cyc(i));
      assign devTab[i]    = (PER_W+1)'(ss_dev_cyc(i));
      assign stepTab[i]   = SQW'(SS_MOD_P / (4 * ss_dev_cyc(i)));
   end

   // edge detection on synchronised levels
   wire syncEdge  = sSync && !syncDly;
   wire enFall    = !sEn && enDly;
   wire thermEdge = sTherm && !thermDly;

   // state decode
   wire running  = (state == ST_RAMP) || (state == ST_WAIT_LED)
                   || (state == ST_ADAPT);
   wire tickLimitHit =
      (state == ST_DETECT)  ? (tick >= TKW'(DETECT_P - 1))  :
      (state == ST_RAMP)    ? (tick >= TKW'(RAMP_P - 1))    :
      (state == ST_RECOVER) ? (tick >= TKW'(RECOVER_P - 1)) :
                              (tick >= TKW'(ADAPT_P - 1));
   wire syncLost = extSyncMode && (idleCnt >= TKW'(SYNC_LOSS_P - 1));
   wire pausing  = pauseCnt != '0;

   // adaptive decision over used, fault-free sinks only
   wire [NSINK-1:0] watched = sink.used & ~sink.fault;
   wire anyLow   = |(watched & sink.low);
   wire allHigh  = (watched != '0) && (&(~watched | sink.high));
   wire stepUp   = anyLow && (targetLevel < TGT_MAX);
   wire stepDown = !anyLow && allHigh && (targetLevel > TGT_MIN);

   // supervision events
   wire uvExpire  = running && sUv
                    && (uvCnt >= UVW'(UV_TIMEOUT_P - 1));
   wire ovHighHit = running && sOvHigh;
   wire clearReq  = hostClear || enFall;

   // flags: a set in the clear cycle wins over the clear
   assign next_status.ovLow =
      (running && sOvLow) || (status.ovLow && !clearReq);
   assign next_status.ovHigh =
      ovHighHit || (status.ovHigh && !clearReq);
   assign next_status.uvTimeout =
      uvExpire || (status.uvTimeout && !clearReq);
   assign next_status.thermal =
      thermEdge || (status.thermal && !clearReq);

   // effective period, spread only on the internal clock
   wire signed [PER_W:0] perSum = $signed({1'b0, periodTab[strap]})
                                  + ((spreadActive && !extSyncMode)
                                     ? ssOffs : '0);
   wire [PER_W-1:0] effPeriod = perSum[PER_W-1:0];

   // switching stops in lower overvoltage, LEDs are not touched
   wire gateInhibit = !running || sOvLow || pausing;

   // state sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE:     if (sEn) next_state = ST_DETECT;
         ST_DETECT:   if (tickLimitHit) next_state = ST_RAMP;
         ST_RAMP:     if (targetLevel >= TGT_INIT)
                         next_state = ST_WAIT_LED;
         ST_WAIT_LED: if (ledActive) next_state = ST_ADAPT;
         ST_ADAPT:    if (!ledActive) next_state = ST_WAIT_LED;
         ST_RECOVER:  if (tickLimitHit) next_state = ST_RAMP;
      endcase
      if (running && (ovHighHit || uvExpire))
         next_state = ST_RECOVER;
      if (!sEn)
         next_state = ST_IDLE;
   end

   // state, delays and shared tick
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state    <= ST_IDLE;
         syncDly  <= 1'b0;
         enDly    <= 1'b0;
         thermDly <= 1'b0;
         tick     <= '0;
         status   <= '0;
      end else begin
         state    <= next_state;
         syncDly  <= sSync;
         enDly    <= sEn;
         thermDly <= sTherm;
         status   <= next_status;
         if (next_state != state || tickLimitHit)
            tick <= '0;
         else
            tick <= tick + TKW'(1);
      end
   end

   // strap caught while idle, held once running
   always_ff @(posedge ref_clk) begin
      if (!rstn)
         strap <= '0;
      else if (state == ST_IDLE)
         strap <= sStrap;
   end

   // external clock detection at start-up and loss watch
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         extSyncMode <= 1'b0;
         edgeCnt     <= '0;
         idleCnt     <= '0;
         pauseCnt    <= '0;
      end else if (state == ST_IDLE) begin
         extSyncMode <= 1'b0;
         edgeCnt     <= '0;
         idleCnt     <= '0;
         pauseCnt    <= '0;
      end else begin
         if (state == ST_DETECT && syncEdge && !(&edgeCnt))
            edgeCnt <= edgeCnt + 4'h1;
         if (state == ST_DETECT && tickLimitHit)
            extSyncMode <= edgeCnt >= 4'(SYNC_EDGES_MIN);
         idleCnt <= (syncEdge || !extSyncMode) ? '0 : idleCnt + TKW'(1);
         if (syncLost) begin
            extSyncMode <= 1'b0;
            if (sSync)
               pauseCnt <= PSW'(SS_PAUSE_P);
         end else if (pausing) begin
            pauseCnt <= pauseCnt - PSW'(1);
         end
      end
   end

   // spread follows the static pin level, held off during the pause
   always_ff @(posedge ref_clk) begin
      if (!rstn)
         spreadActive <= 1'b0;
      else
         spreadActive <= !extSyncMode && sSync && !pausing
                         && state != ST_IDLE;
   end

   // triangle modulation of the period, one sweep per modulation cycle
   always_ff @(posedge ref_clk) begin
      if (!rstn || !spreadActive) begin
         stepCnt <= '0;
         ssOffs  <= '0;
         ssUp    <= 1'b1;
      end else if (stepCnt >= stepTab[strap] - SQW'(1)) begin
         stepCnt <= '0;
         if (ssUp && ssOffs >= devTab[strap]) begin
            ssUp   <= 1'b0;
            ssOffs <= ssOffs - (PER_W+1)'(1);
         end else if (!ssUp && ssOffs <= -devTab[strap]) begin
            ssUp   <= 1'b1;
            ssOffs <= ssOffs + (PER_W+1)'(1);
         end else begin
            ssOffs <= ssUp ? ssOffs + (PER_W+1)'(1)
                           : ssOffs - (PER_W+1)'(1);
         end
      end else begin
         stepCnt <= stepCnt + SQW'(1);
      end
   end

   // undervoltage timeout, cleared as soon as the output recovers
   always_ff @(posedge ref_clk) begin
      if (!rstn || !running || !sUv)
         uvCnt <= '0;
      else if (!uvExpire)
         uvCnt <= uvCnt + UVW'(1);
   end

   // output target: ramp to initial level, then adaptive steps
   always_ff @(posedge ref_clk) begin
      if (!rstn || state == ST_IDLE || state == ST_RECOVER) begin
         targetLevel <= TGT_MIN;
      end else if (state == ST_RAMP && tickLimitHit
                   && targetLevel < TGT_INIT) begin
         targetLevel <= targetLevel + TGT_W'(1);
      end else if (state == ST_ADAPT && tickLimitHit) begin
         if (stepUp)
            targetLevel <= targetLevel + TGT_W'(1);
         else if (stepDown)
            targetLevel <= targetLevel - TGT_W'(1);
      end
   end

   // recovery flag and open-drain interrupt, registered
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         faultRecovery <= 1'b0;
         intOe         <= 1'b0;
      end else begin
         faultRecovery <= next_state == ST_RECOVER;
         intOe         <= |next_status;
      end
   end

   // the pin is only ever pulled low
   assign intOut = 1'b0;

   // gate generator, external edges restart the cycle
   bsac_switch_gen #(
      .PW (PER_W)
   ) u_switch (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .periodCyc (effPeriod),
      .useExt    (extSyncMode),
      .extStart  (syncEdge),
      .inhibit   (gateInhibit),
      .curLimit  (sCurLim),
      .gate      (boostGate)
   );
endmodule

// file: core/bsac_pkg.sv
// bsac_pkg: constants, tables and carriers of the boost supervisor
// assumes a 50 MHz core clock and six LED current sinks
package bsac_pkg;
   // core clock and widths
   localparam int CLK_HZ = 50_000_000;
   localparam int NSINK  = 6;
   localparam int TGT_W  = 8;
   localparam int PER_W  = 8;
   localparam int STRAP_W = 3;

   // strap-selected switching rates in kHz, index = strap code
   localparam int FREQ_KHZ [8] = '{303, 400, 606, 800, 1000, 1250, 1667, 2200};

   // undervoltage timeout, longest time so rounded down
   localparam int UV_TIMEOUT_MS  = 100;
   localparam int UV_TIMEOUT_CYC = UV_TIMEOUT_MS * (CLK_HZ / 1000);

   // switching pause after sync loss with the pin resting high
   localparam int SS_PAUSE_US  = 256;
   localparam int SS_PAUSE_CYC = SS_PAUSE_US * (CLK_HZ / 1_000_000);

   // spread spectrum: modulation rate in mHz and deviation in percent
   localparam int SS_MOD_MHZ = 1_875_000;
   localparam int SS_MOD_CYC = int'(longint'(CLK_HZ) * 1000 / SS_MOD_MHZ);
   localparam int SS_DEV_PCT = 3;

   // output target levels
   localparam int INIT_PCT = 88;
   localparam logic [TGT_W-1:0] TGT_MAX  = 8'hFF;
   localparam logic [TGT_W-1:0] TGT_MIN  = 8'h20;
   localparam logic [TGT_W-1:0] TGT_INIT =
      TGT_W'(int'(TGT_MAX) * INIT_PCT / 100);

   // sequencing counts in core cycles, SYNC_EDGES_MIN in sync edges
   localparam int DETECT_CYC     = 1000;
   localparam int SYNC_EDGES_MIN = 4;
   localparam int SYNC_LOSS_CYC  = 400;
   localparam int RAMP_CYC       = 250;
   localparam int ADAPT_CYC      = 2500;
   localparam int RECOVER_CYC    = 2500;
   localparam int MIN_OFF_CYC    = 3;

   // switching period in core cycles for one strap code
   function automatic int period_cyc(int idx);
      return CLK_HZ / (FREQ_KHZ[idx] * 1000);
   endfunction

   // spread deviation in core cycles, never below one
   function automatic int ss_dev_cyc(int idx);
      int d;
      d = period_cyc(idx) * SS_DEV_PCT / 100;
      return (d < 1) ? 1 : d;
   endfunction

   // latched status flags
   typedef struct packed {
      logic ovLow;
      logic ovHigh;
      logic uvTimeout;
      logic thermal;
   } bsac_status_t;

   // per-sink state seen by the adaptive loop
   typedef struct packed {
      logic [NSINK-1:0] used;
      logic [NSINK-1:0] fault;
      logic [NSINK-1:0] low;
      logic [NSINK-1:0] high;
   } bsac_sink_t;
endpackage

// file: core/bsac_switch_gen.sv
// bsac_switch_gen: boost switch gate with per-cycle current limit
// assumes curLimit and extStart are already in the ref_clk domain
`timescale 1ns/1ps
module bsac_switch_gen
   import bsac_pkg::*;
#(
   parameter int PW = PER_W
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // cycle timing
   input  wire logic [PW-1:0] periodCyc,
   input  wire logic          useExt,
   input  wire logic          extStart,
   // gating
   input  wire logic          inhibit,
   input  wire logic          curLimit,
   output logic               gate
);
   logic [PW-1:0] phase;

   // cycle start from own counter or from the external edge
   wire intStart = !useExt && (phase >= periodCyc - PW'(1));
   wire cycStart = useExt ? extStart : intStart;
   wire maxOnHit = phase >= periodCyc - PW'(MIN_OFF_CYC);
   wire endOn    = curLimit || maxOnHit || inhibit;
   wire phaseTop = &phase;

   // phase saturates so a slow external clock cannot wrap it
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         phase <= '0;
         gate  <= 1'b0;
      end else if (cycStart) begin
         phase <= '0;
         gate  <= !inhibit && !curLimit;
      end else begin
         if (!phaseTop)
            phase <= phase + PW'(1);
         if (endOn)
            gate <= 1'b0;
      end
   end
endmodule

// file: dv/bsac_stage_model.sv
// bsac_stage_model: power stage, LED strings and sync source
// assumes it sits on ref_clk beside bsac_top and drives its pins
`timescale 1ns/1ps
module bsac_stage_model
   import bsac_pkg::*;
#(
   parameter int ON_LIM = 8
) (
   // clock and stimulus
   input  wire logic                  ref_clk,
   input  wire logic                  syncRun,
   input  wire logic                  syncLvl,
   input  wire logic [NSINK-1:0][8:0] need,
   // from the controller, plus the sinkUsed that it is also given
   input  wire logic                  boostGate,
   input  wire logic [TGT_W-1:0]      targetLevel,
   input  wire logic [NSINK-1:0]      sinkUsed,
   // back to the controller
   output logic                       boostClockSyncInput,
   output logic                       currentLimitHit,
   output logic [NSINK-1:0]           sinkBelowLow,
   output logic [NSINK-1:0]           sinkAboveHigh
);
   int onCnt = 0;
   int sCnt = 0;
   // switch current climbs while on, so the limit trips ON_LIM cycles into on-time
   always_ff @(posedge ref_clk) begin
      onCnt <= boostGate ? onCnt + 1 : 0;
      sCnt  <= (syncRun && sCnt < 119) ? sCnt + 1 : 0;
   end
   assign currentLimitHit = boostGate && onCnt >= ON_LIM;
   // sync clock 1.37x the lowest strap rate, else a static level
   assign boostClockSyncInput = syncRun ? (sCnt < 60) : syncLvl;
   // headroom; unused pins sit at ground so they look starved
   always_comb begin
      for (int i = 0; i < NSINK; i++) begin
         sinkBelowLow[i]  = !sinkUsed[i] || 9'(targetLevel) < need[i];
         sinkAboveHigh[i] = sinkUsed[i] && 9'(targetLevel) > need[i] + 9'h002;
      end
   end
endmodule

// file: dv/bsac_top_props.sv
// bsac_top_props: port-level checks of the boost supervisor
// assumes it is bound into bsac_top and sees only its ports
`timescale 1ns/1ps
module bsac_top_props
   import bsac_pkg::*;
#(
   parameter int UV_TIMEOUT_P = UV_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // inputs
   input  wire logic             currentLimitHit,
   input  wire logic             overvoltageLowerLevel,
   input  wire logic             undervoltageLevel,
   input  wire logic             ledActive,
   // outputs
   input  wire logic             boostGate,
   input  wire logic [TGT_W-1:0] targetLevel,
   input  wire logic             extSyncMode,
   input  wire logic             spreadActive,
   input  wire logic             faultRecovery,
   input  wire bsac_status_t     status,
   input  wire logic             intOut,
   input  wire logic             intOe
);
   int uvCnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // run length of raw undervoltage, sync lag makes it lead the design
   always_ff @(posedge ref_clk) begin
      uvCnt <= (rstn && undervoltageLevel) ? uvCnt + 1 : 0;
   end
   lim_cut_a: assert property
      ($rose(currentLimitHit) |-> ##[1:4] !boostGate)
      else $error("gate stayed on past current limit");
   ovl_stop_a: assert property
      (overvoltageLowerLevel [*5] |-> !boostGate)
      else $error("gate on during low overvoltage");
   ovl_flag_a: assert property
      ($rose(status.ovLow) |-> $past(overvoltageLowerLevel, 2))
      else $error("low overvoltage flag without cause");
   ovh_rec_a: assert property
      ($rose(status.ovHigh) |-> ##[0:1] faultRecovery)
      else $error("high overvoltage without recovery");
   int_line_a: assert property
      (intOe == (|status) && !intOut)
      else $error("interrupt line disagrees with flags");
   tgt_floor_a: assert property (targetLevel >= TGT_MIN)
      else $error("target below minimum");
   init_hold_a: assert property
      (targetLevel > $past(targetLevel) && targetLevel > TGT_INIT
       |-> $past(ledActive))
      else $error("target above initial level without LEDs");
   down_step_a: assert property
      (targetLevel < $past(targetLevel) |-> targetLevel == TGT_MIN ||
       (targetLevel == $past(targetLevel) - 8'h01 && $past(ledActive)))
      else $error("bad downward target step");
   uv_wait_a: assert property
      ($rose(status.uvTimeout) |-> uvCnt >= UV_TIMEOUT_P + 1)
      else $error("undervoltage timeout too early");
   ext_spread_a: assert property
      (extSyncMode && $past(extSyncMode) |-> !spreadActive)
      else $error("spread on with external clock");
   cover property ($rose(extSyncMode));
   cover property ($rose(status.uvTimeout));
   cover property (targetLevel == TGT_MAX);
endmodule

bind bsac_top bsac_top_props #(.UV_TIMEOUT_P(UV_TIMEOUT_P)) props_u (
   .ref_clk(ref_clk), .rstn(rstn), .currentLimitHit(currentLimitHit),
   .overvoltageLowerLevel(overvoltageLowerLevel),
   .undervoltageLevel(undervoltageLevel), .ledActive(ledActive),
   .boostGate(boostGate), .targetLevel(targetLevel),
   .extSyncMode(extSyncMode), .spreadActive(spreadActive),
   .faultRecovery(faultRecovery), .status(status), .intOut(intOut),
   .intOe(intOe));

// file: dv/bsac_top_tb_top.sv
// bsac_top_tb_top: self-checking bench of the boost supervisor
// assumes bsac_top, the stage model and the checker are compiled
`timescale 1ns/1ps
module bsac_top_tb_top
   import bsac_pkg::*;
;
   logic ref_clk, rstn, syncRun, syncLvl, en, ovL, ovH, uv, therm;
   logic ledAct, hclr, sync, limit, gate, ext, spread, rec, intO, intOe;
   logic [STRAP_W-1:0]    strap;
   logic [NSINK-1:0]      used, fault, below, above;
   logic [NSINK-1:0][8:0] need;
   logic [TGT_W-1:0]      tgt;
   bsac_status_t          st;
   int                    err_total, checks_done, cyc;
   // short counts keep the run brief; detect, loss and recovery keep
   // their real lengths so those counters run as shipped
   bsac_top #(.UV_TIMEOUT_P(200), .SS_PAUSE_P(50), .SS_MOD_P(400),
      .RAMP_P(4), .ADAPT_P(10)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .boostClockSyncInput(sync),
      .boostFrequencyStrap(strap), .enablePin(en), .currentLimitHit(limit),
      .overvoltageLowerLevel(ovL), .overvoltageUpperLevel(ovH),
      .undervoltageLevel(uv), .thermalCrossing(therm), .sinkBelowLow(below),
      .sinkAboveHigh(above), .sinkUsed(used), .sinkFault(fault),
      .ledActive(ledAct), .hostClear(hclr), .boostGate(gate),
      .targetLevel(tgt), .extSyncMode(ext), .spreadActive(spread),
      .faultRecovery(rec), .status(st), .intOut(intO), .intOe(intOe));
   bsac_stage_model stage_u (
      .ref_clk(ref_clk), .syncRun(syncRun), .syncLvl(syncLvl), .need(need),
      .boostGate(gate), .targetLevel(tgt), .sinkUsed(used),
      .boostClockSyncInput(sync), .currentLimitHit(limit),
      .sinkBelowLow(below), .sinkAboveHigh(above));
   // 50 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // hang guard, about twice the expected run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // inputs always change 1 ns after the edge
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // enable from idle, then sit out the detect window
   task automatic start();
      en = 1'b0;
      tick(6);
      en = 1'b1;
      tick(1010);
   endtask
   // bounded wait for a target, then let it settle
   task automatic wait_tgt(logic [7:0] exp, int lim);
      for (int k = 0; k < lim && tgt !== exp; k++) begin
         tick(1);
      end
      tick(30);
   endtask
   task automatic t_strap();
      int t0;
      for (int c = 0; c < 8; c++) begin
         strap = 3'(c);
         start();
         @(posedge gate);
         t0 = cyc;
         @(posedge gate);
         chk("period", 16'(cyc - t0), 16'(50000 / FREQ_KHZ[c]));
         #1;
      end
      chk("ext mode", ext, 1'b0);
   endtask
   task automatic t_sync();
      for (int lv = 0; lv < 2; lv++) begin
         strap = 3'h0;
         syncRun = 1'b1;
         start();
         chk("ext mode", ext, 1'b1);
         chk("spread", spread, 1'b0);
         syncLvl = lv[0];
         syncRun = 1'b0;
         for (int k = 0; k < 500 && ext; k++) begin
            tick(1);
         end
         chk("ext lost", ext, 1'b0);
         chk("pause spread", spread, 1'b0);
         tick(60);
         chk("spread", spread, 16'(lv[0]));
      end
   endtask
   // spread on: each period wanders off the strap period by at most 3%
   task automatic t_spread();
      int t0, p, bad, moved, nom, dev;
      nom   = 50000 / FREQ_KHZ[0];
      dev   = nom * SS_DEV_PCT / 100;
      moved = 0;
      @(posedge gate);
      for (int k = 0; k < 4; k++) begin
         t0 = cyc;
         @(posedge gate);
         p   = cyc - t0;
         bad = (p > nom + dev) || (p < nom - dev);
         chk("spread span", 16'(bad), 16'h0000);
         if (p != nom)
            moved++;
      end
      chk("spread moves", 16'(moved != 0), 16'h0001);
      #1;
   endtask
   // unused sinks starve and sink 1 is faulted: both must be ignored
   task automatic t_adapt();
      syncLvl = 1'b0;
      {used, fault, need[1], need[0]} = {6'h03, 6'h02, 9'h1FF, 9'h0F0};
      start();
      wait_tgt(TGT_INIT, 1000);
      chk("initial target", tgt, TGT_INIT);
      ledAct = 1'b1;
      wait_tgt(8'hF0, 400);
      chk("target up", tgt, 8'hF0);
      {used, need[2], need[0]} = {6'h05, 9'h060, 9'h040};
      wait_tgt(8'h62, 2000);
      chk("target down", tgt, 8'h62);
      {need[2], need[0]} = '0;
      wait_tgt(TGT_MIN, 1000);
      chk("target floor", tgt, TGT_MIN);
      need[0] = 9'h1FF;
      wait_tgt(TGT_MAX, 2600);
      chk("target ceiling", tgt, TGT_MAX);
   endtask
   task automatic t_flags();
      ovL = 1'b1;
      tick(10);
      chk("ov low flag", st.ovLow, 1'b1);
      chk("int enable", intOe, 1'b1);
      chk("recovery", rec, 1'b0);
      ovL = 1'b0;
      for (int k = 0; k < 400 && !gate; k++) begin
         tick(1);
      end
      chk("gate resumes", gate, 1'b1);
      therm = 1'b1;
      tick(5);
      therm = 1'b0;
      chk("thermal flag", st.thermal, 1'b1);
      hclr = 1'b1;
      tick(1);
      hclr = 1'b0;
      tick(1);
      chk("cleared", st, 4'h0);
   endtask
   task automatic t_ovh();
      ovH = 1'b1;
      tick(5);
      ovH = 1'b0;
      chk("ov high flag", st.ovHigh, 1'b1);
      chk("recovery", rec, 1'b1);
      en = 1'b0;
      tick(5);
      chk("enable clear", st, 4'h0);
   endtask
   task automatic t_uv();
      start();
      uv = 1'b1;
      tick(150);
      uv = 1'b0;
      tick(5);
      chk("uv short", st.uvTimeout, 1'b0);
      uv = 1'b1;
      tick(195);
      chk("uv early", st.uvTimeout, 1'b0);
      tick(15);
      chk("uv flag", st.uvTimeout, 1'b1);
      chk("uv recovery", rec, 1'b1);
      uv = 1'b0;
   endtask
   // reset, then each scenario in turn
   initial begin
      {rstn, en, ovL, ovH, uv, therm, ledAct, hclr} = '0;
      {syncRun, syncLvl, strap, used, fault, need} = '0;
      {err_total, checks_done, cyc} = '0;
      tick(6);
      rstn = 1'b1;
      tick(3);
      chk("reset target", tgt, TGT_MIN);
      chk("reset status", st, 4'h0);
      t_strap();
      t_sync();
      t_spread();
      t_adapt();
      t_flags();
      t_ovh();
      t_uv();
      results();
   end
endmodule
